//--- pmvt_pkg.sv
`default_nettype none
package pmvt_pkg;
  timeunit 1ns / 1ps;
  // =====================================================
  // sizes and vectors
  localparam int ADDR_W = 12;
  localparam int WORD_W = 15;
  localparam logic [11:0] RESET_VEC = 12'h000;
  localparam logic [11:0] EXT_INT_VEC = 12'h004;
  localparam logic [11:0] TMR0_VEC = 12'h008;
  localparam logic [11:0] TMR1_VEC = 12'h00c;
  localparam logic [3:0] LAST_PAGE = 4'hf;
  // =====================================================
  // register map and reset values
  localparam logic [3:0] REG_TBL_PTR = 4'h0;
  localparam logic [3:0] REG_TBL_HIGH = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_PC_LOW = 4'h3;
  localparam logic [3:0] REG_PC_HIGH = 4'h4;
  localparam logic [7:0] TBL_PTR_RST = 8'h00;
  localparam logic [7:0] TBL_HIGH_RST = 8'h00;
  // =====================================================
  // serial programming frame: op bit, 12 address bits, 15 data bits
  localparam logic [4:0] ISP_ADDR_LAST = 5'h0c;
  localparam logic [4:0] ISP_DATA_LAST = 5'h1b;
  // =====================================================
  // types
  typedef enum logic [2:0] {
    OP_NONE, OP_NEXT, OP_SKIP, OP_JUMP, OP_PCL, OP_RET, OP_TRDC, OP_TRDL
  } pmvt_op_t;
  typedef struct packed {
    pmvt_op_t op;
    logic [11:0] target;
    logic [7:0] dest;
  } pmvt_cmd_t;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } pmvt_dm_wr_t;
  typedef struct packed {
    logic req;
    logic [11:0] ret_addr;
  } pmvt_ack_t;
  typedef enum logic {ST_RUN, ST_TBL_DATA} pmvt_state_t;
endpackage : pmvt_pkg
`default_nettype wire

//--- pmvt_prog_mem.sv
`default_nettype none
// Operation
// - program store of 4K words of 15 bits, fetch, tables and vectors
// - reset loads program counter with 000H and fetch starts there
// - enabled falling-edge external interrupt, stack not full, branches to 004H
// - enabled timer 0 overflow, stack not full, branches to 008H
// - enabled timer 1 overflow, stack not full, branches to 00CH
// - software-writable table pointer gives low 8 bits of table address
// - table read from current page or from last page
// - last page starts at 0F00H; pointer 06H reads 0F06H
// - table read writes low byte into the operand data register
// - table read loads upper word part into high latch, extra top bit reads zero
// - high latch is read-only, changed only by table reads
// - each table read takes two instruction cycles
// - store programmable in-circuit over five lines
// - programming data both ways on one pin, clock from programmer
// - current page uses PC bits 11..8; last page forces them to ones
// - stack full: flag still set, vectoring waits for a freed level
module pmvt_prog_mem #(
  parameter int ADDR_W = pmvt_pkg::ADDR_W,
  parameter int WORD_W = pmvt_pkg::WORD_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire pmvt_pkg::pmvt_cmd_t core_cmd,
  input wire logic stack_full,
  input wire logic ext_int_en,
  input wire logic tmr0_int_en,
  input wire logic tmr1_int_en,
  input wire logic tmr0_ovf,
  input wire logic tmr1_ovf,
  input wire logic ext_int_pin_n,
  output logic [WORD_W-1:0] fetch_word,
  output logic fetch_valid,
  output logic [ADDR_W-1:0] pc,
  output logic busy,
  output pmvt_pkg::pmvt_dm_wr_t dm_wr,
  output pmvt_pkg::pmvt_ack_t int_ack,
  input wire logic isp_mode_pin,
  input wire logic isp_clock_pin,
  input wire logic isp_data_pin_i,
  output logic isp_data_pin_o,
  output logic isp_data_pin_oe
);
  timeunit 1ns / 1ps;
  // =====================================================
  // storage
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] rd_addr;
  logic [WORD_W-1:0] mem_q;
  logic mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [WORD_W-1:0] mem_wdata;

  always_ff @(posedge mclk) begin
    if (ce) begin
      mem_q <= mem[rd_addr];
      if (mem_we) begin
        mem[mem_waddr] <= mem_wdata;
      end
    end
  end

  // =====================================================
  // pin synchronisers
  logic ext_s1_reg, ext_s2_reg, ext_s2_next;
  logic [2:0] isp_s1_reg, isp_s2_reg, isp_s2_next;
  logic ext_prev_reg, isp_clk_prev_reg;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ext_s1_reg <= 1'b1;
      ext_s2_reg <= 1'b1;
      isp_s1_reg <= 3'h0;
      isp_s2_reg <= 3'h0;
      ext_prev_reg <= 1'b1;
      isp_clk_prev_reg <= 1'b0;
    end else if (ce) begin
      ext_s1_reg <= ext_int_pin_n;
      ext_s2_reg <= ext_s2_next;
      isp_s1_reg <= {isp_mode_pin, isp_clock_pin, isp_data_pin_i};
      isp_s2_reg <= isp_s2_next;
      ext_prev_reg <= ext_s2_reg;
      isp_clk_prev_reg <= isp_s2_reg[1];
    end
  end

  always_comb begin
    ext_s2_next = ext_s1_reg;
    isp_s2_next = isp_s1_reg;
  end

  logic ext_fall, isp_mode, isp_rise;
  always_comb begin
    ext_fall = ext_prev_reg && !ext_s2_reg;
    isp_mode = isp_s2_reg[2];
    isp_rise = isp_s2_reg[1] && !isp_clk_prev_reg;
  end

  // =====================================================
  // vector priority: external, then timer 0, then timer 1
  function automatic logic [11:0] pick_vec(input logic [2:0] p);
    if (p[0]) begin
      pick_vec = pmvt_pkg::EXT_INT_VEC;
    end else if (p[1]) begin
      pick_vec = pmvt_pkg::TMR0_VEC;
    end else begin
      pick_vec = pmvt_pkg::TMR1_VEC;
    end
  endfunction : pick_vec

  // =====================================================
  // core side state
  pmvt_pkg::pmvt_state_t st_reg, st_next;
  logic [ADDR_W-1:0] pc_reg, pc_next;
  logic [7:0] tbl_ptr_reg, tbl_ptr_next;
  logic [7:0] tbl_high_reg, tbl_high_next;
  logic [7:0] dest_reg, dest_next;
  logic [2:0] pend_reg, pend_next;
  logic fv_reg, fv_next;
  logic busy_reg, busy_next;
  logic [7:0] rdata_reg, rdata_next;
  pmvt_pkg::pmvt_dm_wr_t dm_reg, dm_next;
  pmvt_pkg::pmvt_ack_t ack_reg, ack_next;
  logic [2:0] pend_set, pend_clr;

  // isp state
  logic [4:0] isp_cnt_reg, isp_cnt_next;
  logic isp_wr_op_reg, isp_wr_op_next;
  logic [ADDR_W-1:0] isp_addr_reg, isp_addr_next;
  logic [WORD_W-1:0] isp_sh_reg, isp_sh_next;
  logic isp_load_reg, isp_load_next;
  logic isp_oe_reg, isp_oe_next;
  logic isp_do_reg, isp_do_next;

  always_comb begin
    st_next = st_reg;
    pc_next = pc_reg;
    tbl_ptr_next = tbl_ptr_reg;
    tbl_high_next = tbl_high_reg;
    dest_next = dest_reg;
    fv_next = 1'b1;
    busy_next = 1'b0;
    rdata_next = 8'h00;
    dm_next = '0;
    ack_next = '0;
    rd_addr = pc_reg;
    pend_clr = 3'h0;
    pend_set = {tmr1_ovf && tmr1_int_en, tmr0_ovf && tmr0_int_en, ext_fall && ext_int_en};
    // bus: table high has no write path
    if (bus_wr && bus_addr == pmvt_pkg::REG_TBL_PTR) begin
      tbl_ptr_next = bus_wdata;
    end
    if (bus_rd) begin
      if (bus_addr == pmvt_pkg::REG_TBL_PTR) begin
        rdata_next = tbl_ptr_reg;
      end else if (bus_addr == pmvt_pkg::REG_TBL_HIGH) begin
        rdata_next = tbl_high_reg;
      end else if (bus_addr == pmvt_pkg::REG_STATUS) begin
        rdata_next = {3'h0, isp_mode, busy_reg, pend_reg};
      end else if (bus_addr == pmvt_pkg::REG_PC_LOW) begin
        rdata_next = pc_reg[7:0];
      end else if (bus_addr == pmvt_pkg::REG_PC_HIGH) begin
        rdata_next = {4'h0, pc_reg[11:8]};
      end else begin
        rdata_next = 8'h00;
      end
    end
    if (isp_mode) begin
      // programming owns the array; execution halts
      fv_next = 1'b0;
      // look ahead one shift so the word is ready when the load strobe fires
      rd_addr = isp_addr_next;
      st_next = pmvt_pkg::ST_RUN;
    end else begin
      case (st_reg)
        pmvt_pkg::ST_RUN: begin
          if (pend_reg != 3'h0 && !stack_full &&
              (core_cmd.op == pmvt_pkg::OP_NEXT || core_cmd.op == pmvt_pkg::OP_NONE)) begin
            // held while stack is full; flag remains pending
            pc_next = pick_vec(pend_reg);
            rd_addr = pc_next;
            ack_next.req = 1'b1;
            ack_next.ret_addr = pc_reg;
            pend_clr = pend_reg & (~pend_reg + 3'h1);
          end else begin
            case (core_cmd.op)
              pmvt_pkg::OP_NEXT: pc_next = pc_reg + 12'h001;
              pmvt_pkg::OP_SKIP: pc_next = pc_reg + 12'h002;
              pmvt_pkg::OP_JUMP: pc_next = core_cmd.target;
              pmvt_pkg::OP_PCL: pc_next = {pc_reg[11:8], core_cmd.target[7:0]};
              pmvt_pkg::OP_RET: pc_next = core_cmd.target;
              pmvt_pkg::OP_TRDC, pmvt_pkg::OP_TRDL: begin
                // data access occupies the array this cycle
                rd_addr = {(core_cmd.op == pmvt_pkg::OP_TRDL) ? pmvt_pkg::LAST_PAGE : pc_reg[11:8],
                           tbl_ptr_reg};
                dest_next = core_cmd.dest;
                fv_next = 1'b0;
                busy_next = 1'b1;
                st_next = pmvt_pkg::ST_TBL_DATA;
              end
              default: pc_next = pc_reg;
            endcase
            if (core_cmd.op != pmvt_pkg::OP_TRDC && core_cmd.op != pmvt_pkg::OP_TRDL) begin
              rd_addr = pc_next;
            end
          end
        end
        pmvt_pkg::ST_TBL_DATA: begin
          dm_next.we = 1'b1;
          dm_next.addr = dest_reg;
          dm_next.data = mem_q[7:0];
          // unused top bit reads as zero
          tbl_high_next = {1'b0, mem_q[WORD_W-1:8]};
          pc_next = pc_reg + 12'h001;
          rd_addr = pc_next;
          st_next = pmvt_pkg::ST_RUN;
        end
        default: st_next = pmvt_pkg::ST_RUN;
      endcase
    end
    // set wins over clear
    pend_next = (pend_reg & ~pend_clr) | pend_set;
  end

  // =====================================================
  // serial programming: bit 0 op, 1..12 address msb first, then 15 data bits
  always_comb begin
    isp_cnt_next = isp_cnt_reg;
    isp_wr_op_next = isp_wr_op_reg;
    isp_addr_next = isp_addr_reg;
    isp_sh_next = isp_sh_reg;
    isp_load_next = 1'b0;
    isp_oe_next = isp_oe_reg;
    isp_do_next = isp_do_reg;
    mem_we = 1'b0;
    mem_waddr = isp_addr_reg;
    mem_wdata = isp_sh_reg;
    if (!isp_mode) begin
      isp_cnt_next = 5'h00;
      isp_oe_next = 1'b0;
    end else begin
      if (isp_load_reg) begin
        isp_sh_next = mem_q;
        isp_do_next = mem_q[WORD_W-1];
        isp_oe_next = 1'b1;
      end
      if (isp_rise) begin
        if (isp_cnt_reg == 5'h00) begin
          isp_wr_op_next = isp_s2_reg[0];
        end else if (isp_cnt_reg <= pmvt_pkg::ISP_ADDR_LAST) begin
          isp_addr_next = {isp_addr_reg[ADDR_W-2:0], isp_s2_reg[0]};
          isp_load_next = (isp_cnt_reg == pmvt_pkg::ISP_ADDR_LAST) && !isp_wr_op_reg;
        end else if (isp_wr_op_reg) begin
          isp_sh_next = {isp_sh_reg[WORD_W-2:0], isp_s2_reg[0]};
          if (isp_cnt_reg == pmvt_pkg::ISP_DATA_LAST) begin
            mem_we = 1'b1;
            mem_wdata = {isp_sh_reg[WORD_W-2:0], isp_s2_reg[0]};
          end
        end else begin
          isp_sh_next = {isp_sh_reg[WORD_W-2:0], 1'b0};
          isp_do_next = isp_sh_reg[WORD_W-2];
        end
        if (isp_cnt_reg == pmvt_pkg::ISP_DATA_LAST) begin
          isp_cnt_next = 5'h00;
          isp_oe_next = 1'b0;
        end else begin
          isp_cnt_next = isp_cnt_reg + 5'h01;
        end
      end
    end
  end

  // =====================================================
  // registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= pmvt_pkg::ST_RUN;
      pc_reg <= pmvt_pkg::RESET_VEC;
      tbl_ptr_reg <= pmvt_pkg::TBL_PTR_RST;
      tbl_high_reg <= pmvt_pkg::TBL_HIGH_RST;
      dest_reg <= 8'h00;
      pend_reg <= 3'h0;
      fv_reg <= 1'b0;
      busy_reg <= 1'b0;
      rdata_reg <= 8'h00;
      dm_reg <= '0;
      ack_reg <= '0;
      isp_cnt_reg <= 5'h00;
      isp_wr_op_reg <= 1'b0;
      isp_addr_reg <= '0;
      isp_sh_reg <= '0;
      isp_load_reg <= 1'b0;
      isp_oe_reg <= 1'b0;
      isp_do_reg <= 1'b0;
    end else if (ce) begin
      st_reg <= st_next;
      pc_reg <= pc_next;
      tbl_ptr_reg <= tbl_ptr_next;
      tbl_high_reg <= tbl_high_next;
      dest_reg <= dest_next;
      pend_reg <= pend_next;
      fv_reg <= fv_next;
      busy_reg <= busy_next;
      rdata_reg <= rdata_next;
      dm_reg <= dm_next;
      ack_reg <= ack_next;
      isp_cnt_reg <= isp_cnt_next;
      isp_wr_op_reg <= isp_wr_op_next;
      isp_addr_reg <= isp_addr_next;
      isp_sh_reg <= isp_sh_next;
      isp_load_reg <= isp_load_next;
      isp_oe_reg <= isp_oe_next;
      isp_do_reg <= isp_do_next;
    end
  end

  always_comb begin
    bus_rdata = rdata_reg;
    fetch_word = mem_q;
    fetch_valid = fv_reg;
    pc = pc_reg;
    busy = busy_reg;
    dm_wr = dm_reg;
    int_ack = ack_reg;
    isp_data_pin_o = isp_do_reg;
    isp_data_pin_oe = isp_oe_reg;
  end
endmodule : pmvt_prog_mem
`default_nettype wire

//--- pmvt_prog_mem_sva.sv
`default_nettype none
// ========
// checker on the program store ports
module pmvt_prog_mem_sva (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [3:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire pmvt_pkg::pmvt_cmd_t core_cmd,
  input wire logic stack_full,
  input wire logic ext_int_en,
  input wire logic tmr0_int_en,
  input wire logic tmr1_int_en,
  input wire logic tmr0_ovf,
  input wire logic tmr1_ovf,
  input wire logic fetch_valid,
  input wire logic [11:0] pc,
  input wire logic busy,
  input wire pmvt_pkg::pmvt_dm_wr_t dm_wr,
  input wire pmvt_pkg::pmvt_ack_t int_ack,
  input wire logic isp_mode_pin,
  input wire logic isp_data_pin_oe
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // raw mode pin: bench keeps commands clear of its edges
  sequence trd_take;
    ce && !busy && !isp_mode_pin && core_cmd.op >= pmvt_pkg::OP_TRDC;
  endsequence
  sequence int_ready;
    ce && !busy && !isp_mode_pin && !stack_full && core_cmd.op <= pmvt_pkg::OP_NEXT;
  endsequence
  reset_vector_a: assert property (
    $rose(rst_n) && ce |-> pc == 12'h000 && !fetch_valid ##1 pc == 12'h000 && fetch_valid
  ) else $error("pc not at reset vector");
  trd_hold_a: assert property (
    trd_take |=> busy && !fetch_valid && $stable(pc)
  ) else $error("table read first cycle wrong");
  trd_end_a: assert property (
    trd_take ##1 ce |=> !busy && fetch_valid && dm_wr.we && dm_wr.addr == $past(core_cmd.dest, 2)
      && pc == $past(pc) + 12'h001
  ) else $error("table read end wrong");
  wr_pulse_a: assert property (
    dm_wr.we |-> $past(busy) ##1 !dm_wr.we
  ) else $error("table byte write out of place");
  ack_vector_a: assert property (
    int_ack.req |-> fetch_valid && pc inside {12'h004, 12'h008, 12'h00c} && int_ack.ret_addr == $past(pc)
  ) else $error("bad interrupt entry");
  full_hold_a: assert property (
    stack_full |=> !int_ack.req
  ) else $error("vectored with full stack");
  t0_vector_a: assert property (
    tmr0_ovf && tmr0_int_en && !ext_int_en ##1 int_ready |=> int_ack.req && pc == 12'h008
  ) else $error("timer 0 entry missed");
  t1_vector_a: assert property (
    tmr1_ovf && tmr1_int_en && !ext_int_en && !tmr0_int_en ##1 int_ready |=> int_ack.req && pc == 12'h00c
  ) else $error("timer 1 entry missed");
  ptr_rw_a: assert property (
    bus_wr && ce && bus_addr == 4'h0 ##1 bus_rd && !bus_wr && ce && bus_addr == 4'h0
      |=> bus_rdata == $past(bus_wdata, 2)
  ) else $error("table pointer readback wrong");
  oe_idle_a: assert property (
    !isp_mode_pin [*4] |-> !isp_data_pin_oe
  ) else $error("data pin driven outside programming");
  isp_halt_a: assert property (
    isp_mode_pin [*4] |-> !fetch_valid && !dm_wr.we
  ) else $error("execution during programming");
endmodule : pmvt_prog_mem_sva
bind pmvt_prog_mem pmvt_prog_mem_sva pmvt_prog_mem_sva_inst (.*);
`default_nettype wire

//--- pmvt_isp_host.sv
`default_nettype none
// ========
// serial programmer on the data and clock pins
module pmvt_isp_host (
  output logic isp_mode_pin,
  output logic isp_clock_pin,
  output logic isp_data_pin_i,
  input wire logic isp_data_pin_o,
  input wire logic isp_data_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv;
  logic smp;
  // one shared line: device wins while it drives
  assign isp_data_pin_i = isp_data_pin_oe ? isp_data_pin_o : drv;
  initial begin
    isp_mode_pin = 1'b0;
    isp_clock_pin = 1'b0;
    drv = 1'b0;
  end
  // clock stands low between bits and frames
  task automatic clk_bit(input logic own, input logic b);
    if (own)
      drv = b;
    #64;
    smp = isp_data_pin_i;
    isp_clock_pin = 1'b1;
    #64;
    isp_clock_pin = 1'b0;
  endtask : clk_bit
  task automatic frame(input logic wr, input logic [11:0] a, input logic [14:0] d, output logic [14:0] q);
    logic [27:0] f;
    f = {wr, a, d};
    #1;
    isp_mode_pin = 1'b1;
    #200;
    for (int i = 27; i >= 0; i--) begin
      // released line shows the inverse, not a stale level
      if (i == 14 && !wr)
        drv = ~drv;
      clk_bit(wr || i > 14, f[i]);
      if (i < 15)
        q[i] = smp;
    end
    #200;
    isp_mode_pin = 1'b0;
    #200;
  endtask : frame
endmodule : pmvt_isp_host
`default_nettype wire

//--- tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, ce, bus_wr, bus_rd, stack_full, ext_int_en, tmr0_int_en, tmr1_int_en;
  logic tmr0_ovf, tmr1_ovf, ext_int_pin_n, fetch_valid, busy;
  logic isp_mode_pin, isp_clock_pin, isp_data_pin_i, isp_data_pin_o, isp_data_pin_oe;
  logic [3:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, dst;
  logic [11:0] pc, p0;
  logic [14:0] fetch_word, q;
  logic [11:0] w_addr [5];
  logic [14:0] w_data [5];
  pmvt_pkg::pmvt_cmd_t core_cmd;
  pmvt_pkg::pmvt_dm_wr_t dm_wr;
  pmvt_pkg::pmvt_ack_t int_ack;
  int errors, total_checks;
  pmvt_prog_mem pmvt_prog_mem_inst (.*);
  pmvt_isp_host pmvt_isp_host_inst (.*);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ========
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask : tick
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask : rd
  // write then read back with no gap between strobes
  task automatic wrrd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge mclk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge mclk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b1;
    @(posedge mclk);
    bus_rd <= 1'b0;
    #1;
    chk(bus_rdata, exp);
  endtask : wrrd
  task automatic cmd(input pmvt_pkg::pmvt_op_t op, input logic [11:0] t, input logic [7:0] d);
    @(posedge mclk);
    core_cmd <= {op, t, d};
    @(posedge mclk);
    core_cmd <= {pmvt_pkg::OP_NONE, 12'h000, 8'h00};
    #1;
  endtask : cmd
  task automatic wait_ack(input logic [11:0] vec, input logic [11:0] ret);
    int n;
    n = 0;
    while (int_ack.req !== 1'b1 && n < 12) begin
      tick;
      n++;
    end
    if (n == 12) begin
      chk(32'h0, 32'h1);
      give_verdict;
    end
    chk({pc, int_ack.ret_addr}, {vec, ret});
  endtask : wait_ack
  // ========
  // main sequence
  initial begin
    errors = 0;
    total_checks = 0;
    {rst_n, bus_wr, bus_rd, stack_full, ext_int_en, tmr0_int_en, tmr1_int_en, tmr0_ovf, tmr1_ovf} = '0;
    ce = 1'b1;
    ext_int_pin_n = 1'b1;
    bus_addr = 4'h0;
    bus_wdata = 8'h00;
    core_cmd = '0;
    w_addr = '{12'h000, 12'hf06, 12'hf05, 12'h306, 12'hfff};
    w_data = '{15'h1234, 15'h7a5c, 15'h00f0, 15'h4b21, 15'h5555};
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk({pc, fetch_valid}, {12'h000, 1'b0});
    rd(pmvt_pkg::REG_TBL_PTR, pmvt_pkg::TBL_PTR_RST);
    rd(pmvt_pkg::REG_TBL_HIGH, pmvt_pkg::TBL_HIGH_RST);
    for (int i = 0; i < 5; i++)
      pmvt_isp_host_inst.frame(1'b1, w_addr[i], w_data[i], q);
    for (int i = 1; i < 5; i += 3) begin
      pmvt_isp_host_inst.frame(1'b0, w_addr[i], 15'h0000, q);
      chk(q, w_data[i]);
    end
    // second reset now that the store holds known words
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    tick;
    chk({pc, fetch_valid, fetch_word}, {12'h000, 1'b1, w_data[0]});
    cmd(pmvt_pkg::OP_JUMP, 12'h3f0, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wrrd(pmvt_pkg::REG_TBL_PTR, (i == 1) ? 8'h05 : 8'h06, (i == 1) ? 8'h05 : 8'h06);
      p0 = pc;
      dst = 8'h40 + 8'(i);
      cmd((i == 2) ? pmvt_pkg::OP_TRDC : pmvt_pkg::OP_TRDL, 12'h000, dst);
      chk({busy, fetch_valid, pc}, {1'b1, 1'b0, p0});
      tick;
      chk({dm_wr.we, dm_wr.addr, dm_wr.data}, {1'b1, dst, w_data[i + 1][7:0]});
      chk({busy, fetch_valid, pc}, {1'b0, 1'b1, p0 + 12'h001});
      rd(pmvt_pkg::REG_TBL_HIGH, {1'b0, w_data[i + 1][14:8]});
    end
    wrrd(pmvt_pkg::REG_TBL_HIGH, 8'hff, {1'b0, w_data[3][14:8]});
    wrrd(4'hf, 8'ha5, 8'h00);
    for (int i = 0; i < 3; i++) begin
      p0 = pc;
      @(posedge mclk);
      ext_int_en <= (i == 0);
      tmr0_int_en <= (i == 1);
      tmr1_int_en <= (i == 2);
      @(posedge mclk);
      ext_int_pin_n <= (i != 0);
      tmr0_ovf <= (i == 1);
      tmr1_ovf <= (i == 2);
      @(posedge mclk);
      tmr0_ovf <= 1'b0;
      tmr1_ovf <= 1'b0;
      #1;
      wait_ack(12'(4 * (i + 1)), p0);
    end
    p0 = pc;
    @(posedge mclk);
    stack_full <= 1'b1;
    tmr0_int_en <= 1'b1;
    tmr1_int_en <= 1'b0;
    tmr0_ovf <= 1'b1;
    @(posedge mclk);
    tmr0_ovf <= 1'b0;
    repeat (8) begin
      tick;
      chk(int_ack.req, 1'b0);
    end
    rd(pmvt_pkg::REG_STATUS, 8'h02);
    @(posedge mclk);
    stack_full <= 1'b0;
    #1;
    wait_ack(12'h008, p0);
    // program counter steering and readback
    p0 = pc;
    cmd(pmvt_pkg::OP_NEXT, 12'h000, 8'h00);
    chk(pc, p0 + 12'h001);
    cmd(pmvt_pkg::OP_SKIP, 12'h000, 8'h00);
    chk(pc, p0 + 12'h003);
    cmd(pmvt_pkg::OP_PCL, 12'hfa5, 8'h00);
    chk(pc, {p0[11:8], 8'ha5});
    cmd(pmvt_pkg::OP_RET, 12'h000, 8'h00);
    chk({pc, fetch_word}, {12'h000, w_data[0]});
    cmd(pmvt_pkg::OP_JUMP, 12'hf06, 8'h00);
    chk(fetch_word, w_data[1]);
    rd(pmvt_pkg::REG_PC_LOW, 8'h06);
    rd(pmvt_pkg::REG_PC_HIGH, 8'h0f);
    // clock enable low must freeze the counter
    @(posedge mclk);
    ce <= 1'b0;
    core_cmd <= {pmvt_pkg::OP_NEXT, 12'h000, 8'h00};
    repeat (3) @(posedge mclk);
    ce <= 1'b1;
    core_cmd <= '0;
    #1;
    chk(pc, 12'hf06);
    give_verdict;
  end
endmodule : tb
`default_nettype wire
